// *** design/tet_pkg.sv ***
// shared constants and filter decode for the external trigger timer block
package tet_pkg;

    localparam int unsigned APB_AW = 8;
    localparam int unsigned APB_DW = 32;

    localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
    localparam logic [7:0] OFS_SLAVE_MODE = 8'h08;
    localparam logic [7:0] OFS_COMM_REQ   = 8'h14;
    localparam logic [7:0] OFS_CH_STAGED  = 8'h20;
    localparam logic [7:0] OFS_CH_ACTIVE  = 8'h24;
    localparam logic [7:0] OFS_TRIG_STAT  = 8'h28;

    localparam int unsigned CT_PRELOAD_BIT = 0;
    localparam int unsigned CT_UPDSEL_BIT  = 2;
    localparam logic [31:0] CT_WR_MASK     = 32'h0000_0005;
    localparam logic [31:0] CT_RESET       = 32'h0000_0000;

    localparam int unsigned SMC_POL_BIT = 15;
    localparam int unsigned SMC_ECE_BIT = 14;
    localparam int unsigned SMC_PSC_LSB = 12;
    localparam int unsigned SMC_FLT_LSB = 8;
    localparam int unsigned SMC_MSS_BIT = 7;
    localparam int unsigned SMC_TSL_LSB = 4;
    localparam int unsigned SMC_SMO_LSB = 0;
    localparam logic [15:0] SMC_WR_MASK = 16'hfff7;
    localparam logic [15:0] SMC_TSL_MASK = 16'h0070;
    localparam logic [15:0] SMC_RESET   = 16'h0000;

    localparam int unsigned COMM_REQ_BIT = 0;

    localparam int unsigned CH_STRIDE   = 8;
    localparam int unsigned CH_OE_BIT   = 0;
    localparam int unsigned CH_CE_BIT   = 1;
    localparam int unsigned CH_MODE_LSB = 4;
    localparam int unsigned CH_MODE_W   = 3;
    localparam logic [7:0]  CH_WR_MASK  = 8'h73;

    localparam logic [2:0] SMO_INTERNAL = 3'h0;
    localparam logic [2:0] SMO_EXT_CLK1 = 3'h7;
    localparam logic [2:0] TSL_FILTERED = 3'h7;

    typedef struct packed {
        logic       use_dts;
        logic [2:0] div_log2;
        logic [3:0] n;
    } tet_flt_cfg_t;

    function automatic tet_flt_cfg_t tet_flt_decode(input logic [3:0] code);
        tet_flt_cfg_t c;
        c = '{use_dts: 1'b1, div_log2: 3'h0, n: 4'h1};
        case (code)
            4'h0: c = '{use_dts: 1'b1, div_log2: 3'h0, n: 4'h1};
            4'h1: c = '{use_dts: 1'b0, div_log2: 3'h0, n: 4'h2};
            4'h2: c = '{use_dts: 1'b0, div_log2: 3'h0, n: 4'h4};
            4'h3: c = '{use_dts: 1'b0, div_log2: 3'h0, n: 4'h8};
            4'h4: c = '{use_dts: 1'b1, div_log2: 3'h1, n: 4'h6};
            4'h5: c = '{use_dts: 1'b1, div_log2: 3'h2, n: 4'h6};
            4'h6: c = '{use_dts: 1'b1, div_log2: 3'h2, n: 4'h8};
            4'h7: c = '{use_dts: 1'b1, div_log2: 3'h2, n: 4'h8};
            4'h8: c = '{use_dts: 1'b1, div_log2: 3'h3, n: 4'h6};
            4'h9: c = '{use_dts: 1'b1, div_log2: 3'h3, n: 4'h8};
            4'ha: c = '{use_dts: 1'b1, div_log2: 3'h4, n: 4'h5};
            4'hb: c = '{use_dts: 1'b1, div_log2: 3'h4, n: 4'h6};
            4'hc: c = '{use_dts: 1'b1, div_log2: 3'h4, n: 4'h8};
            4'hd: c = '{use_dts: 1'b1, div_log2: 3'h5, n: 4'h5};
            4'he: c = '{use_dts: 1'b1, div_log2: 3'h5, n: 4'h6};
            4'hf: c = '{use_dts: 1'b1, div_log2: 3'h5, n: 4'h8};
            default: c = '{use_dts: 1'b1, div_log2: 3'h0, n: 4'h1};
        endcase
        return c;
    endfunction

endpackage

// *** design/tet_flt_if.sv ***
// link between the trigger conditioning top and its digital filter
interface tet_flt_if;
    logic [3:0] code;
    logic       din;
    logic       dout;

    modport ctl  (output code, output din, input dout);
    modport filt (input code, input din, output dout);
endinterface

// *** design/tet_ext_trig_filter.sv ***
// digital event-counter filter for the conditioned external trigger
module tet_ext_trig_filter #(
    parameter int unsigned DTS_DIV = 1
) (
    input wire logic ref_clk,
    input wire logic reset,
    tet_flt_if.filt  flt
);
    localparam int unsigned CW = 8;

    tet_pkg::tet_flt_cfg_t cfg;
    logic [CW-1:0]         period;
    logic [CW-1:0]         smp_cnt_ff;
    logic [CW-1:0]         nxt_smp_cnt;
    logic [3:0]            run_ff;
    logic [3:0]            nxt_run;
    logic                  out_ff;
    logic                  nxt_out;
    logic [3:0]            code_ff;
    logic                  code_chg;
    logic                  tick;
    logic                  mismatch;
    logic                  reached;

    assign cfg    = tet_pkg::tet_flt_decode(flt.code);
    assign period = (cfg.use_dts ? CW'(DTS_DIV) : CW'(1)) << cfg.div_log2;
    assign code_chg = code_ff != flt.code;
    assign tick     = smp_cnt_ff >= (period - CW'(1));
    assign nxt_smp_cnt = (tick || code_chg) ? '0 : smp_cnt_ff + CW'(1);

    // counts consecutive samples that disagree with the output
    assign mismatch = flt.din != out_ff;
    assign reached  = (run_ff + 4'h1) >= cfg.n;
    assign nxt_run  = code_chg ? 4'h0 :
                      !tick ? run_ff :
                      (!mismatch || reached) ? 4'h0 : run_ff + 4'h1;
    assign nxt_out  = (tick && mismatch && reached) ? flt.din : out_ff;
    assign flt.dout = out_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            smp_cnt_ff <= '0;
            run_ff     <= 4'h0;
            out_ff     <= 1'b0;
            code_ff    <= 4'h0;
        end else begin
            smp_cnt_ff <= nxt_smp_cnt;
            run_ff     <= nxt_run;
            out_ff     <= nxt_out;
            code_ff    <= flt.code;
        end
    end
endmodule

// *** design/tet_trig_top.sv ***
// external trigger conditioning and complementary channel preload control
// Function
// - preload on: channel enables and modes wait in shadow for commutation
// - update select 1: software or trigger rise commits; 0: software only
// - preload and update select touch only complementary channels
// - polarity bit 15 set inverts the external trigger pin
// - bit 14 set enables external clock mode 2 from conditioned trigger
// - both external clock modes on: filtered trigger clocks the counter
// - prescaler bits 13:12 divide trigger by 1, 2, 4 or 8
// - filter validates a transition after N consistent samples
// - code 0 no filter at dead-time rate; 1..3 kernel rate, N 2/4/8
// - codes 4, 5, 6 sample dead-time over 2, 4, 4 with N 6, 6, 8
// - codes 8, 9 dead-time over 8; next codes over 16, N 5, 6 or 8
// - codes 13, 14, 15 dead-time over 32 with N 5, 6, 8
// - trigger select 7 routes filtered trigger to trigger input
// - slave mode 7 clocks counter on trigger input rising edges
//
// The APB slave port was chosen for this implementation.
module tet_trig_top #(
    parameter int unsigned NUM_CH   = 4,
    parameter int unsigned NUM_COMP = 3,
    parameter int unsigned DTS_DIV  = 1
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      ext_trig_pin,
    input  wire logic [3:0]                int_trig,
    input  wire logic                      ti1_edge,
    input  wire logic                      ti1_filtered,
    input  wire logic                      ti2_filtered,
    output logic                           ext_trig_filtered,
    output logic                           trigger_input,
    output logic                           trigger_rise,
    output logic                           ext_clk_tick,
    output logic                           comm_event,
    output logic                           master_slave_sync,
    output logic      [2:0]                slave_mode_select,
    output logic      [NUM_CH-1:0]         channel_out_en,
    output logic      [NUM_CH-1:0]         channel_comp_out_en,
    output logic      [NUM_CH*3-1:0]       channel_out_mode
);
    localparam int unsigned SW = NUM_CH * tet_pkg::CH_STRIDE;

    // register state
    logic [31:0]   ctrl_two_ff;
    logic [31:0]   nxt_ctrl_two;
    logic [15:0]   slave_mode_ff;
    logic [15:0]   nxt_slave_mode;
    logic [SW-1:0] ch_staged_ff;
    logic [SW-1:0] nxt_ch_staged;
    logic [SW-1:0] ch_active_word;
    logic [31:0]   prdata_ff;
    logic [31:0]   nxt_prdata;

    // decoded fields
    logic          cc_preload_ctrl;
    logic          cc_update_select;
    logic          ext_trig_polarity;
    logic          ext_clk2_enable;
    logic [1:0]    ext_trig_prescale;
    logic [3:0]    ext_trig_filter;
    logic [2:0]    trigger_select;
    logic [2:0]    slave_mode_cur;

    // bus decode
    logic          acc_phase;
    logic          setup_rd;
    logic          wr_en;
    logic          hit_ctrl_two;
    logic          hit_slave_mode;
    logic          hit_comm_req;
    logic          hit_ch_staged;
    logic          hit_ch_active;
    logic          hit_trig_stat;
    logic          addr_hit;
    logic [15:0]   smc_wdata;
    logic [15:0]   smc_tsl_src;
    logic [31:0]   rd_word;
    logic [31:0]   stat_word;

    // trigger path
    logic          pin_meta_ff;
    logic          pin_sync_ff;
    logic          pol_sig;
    logic          pol_prev_ff;
    logic          pol_rise;
    logic [2:0]    psc_cnt_ff;
    logic [2:0]    nxt_psc_cnt;
    logic          ext_trig_prescaled;
    logic          filt_prev_ff;
    logic          filt_rise;
    logic [7:0]    trig_src;
    logic          trig_in_ff;
    logic          trig_prev_ff;
    logic          nxt_clk_tick;
    logic          clk_tick_ff;
    logic          sw_comm;
    logic          comm_now;
    logic          comm_ff;

    tet_flt_if flt_bus ();

    assign cc_preload_ctrl   = ctrl_two_ff[tet_pkg::CT_PRELOAD_BIT];
    assign cc_update_select  = ctrl_two_ff[tet_pkg::CT_UPDSEL_BIT];
    assign ext_trig_polarity = slave_mode_ff[tet_pkg::SMC_POL_BIT];
    assign ext_clk2_enable   = slave_mode_ff[tet_pkg::SMC_ECE_BIT];
    assign ext_trig_prescale = slave_mode_ff[tet_pkg::SMC_PSC_LSB +: 2];
    assign ext_trig_filter   = slave_mode_ff[tet_pkg::SMC_FLT_LSB +: 4];
    assign trigger_select    = slave_mode_ff[tet_pkg::SMC_TSL_LSB +: 3];
    assign slave_mode_cur    = slave_mode_ff[tet_pkg::SMC_SMO_LSB +: 3];

    // ---------------- APB slave ----------------
    // zero wait states: read data is captured during the setup cycle
    assign acc_phase = psel && penable;
    assign setup_rd  = psel && !penable && !pwrite;
    assign wr_en     = acc_phase && pwrite;

    assign hit_ctrl_two   = paddr == tet_pkg::OFS_CTRL_TWO;
    assign hit_slave_mode = paddr == tet_pkg::OFS_SLAVE_MODE;
    assign hit_comm_req   = paddr == tet_pkg::OFS_COMM_REQ;
    assign hit_ch_staged  = paddr == tet_pkg::OFS_CH_STAGED;
    assign hit_ch_active  = paddr == tet_pkg::OFS_CH_ACTIVE;
    assign hit_trig_stat  = paddr == tet_pkg::OFS_TRIG_STAT;
    assign addr_hit = hit_ctrl_two || hit_slave_mode || hit_comm_req
                   || hit_ch_staged || hit_ch_active || hit_trig_stat;

    assign pready  = 1'b1;
    assign pslverr = acc_phase && !addr_hit;

    assign nxt_ctrl_two = (wr_en && hit_ctrl_two)
                        ? (pwdata & tet_pkg::CT_WR_MASK) : ctrl_two_ff;

    // trigger select may only change while slave mode reads internal clock
    assign smc_wdata   = pwdata[15:0] & tet_pkg::SMC_WR_MASK;
    assign smc_tsl_src = (slave_mode_cur == tet_pkg::SMO_INTERNAL)
                       ? smc_wdata : slave_mode_ff;
    assign nxt_slave_mode = (wr_en && hit_slave_mode)
                          ? ((smc_wdata & ~tet_pkg::SMC_TSL_MASK)
                             | (smc_tsl_src & tet_pkg::SMC_TSL_MASK))
                          : slave_mode_ff;

    assign nxt_ch_staged = (wr_en && hit_ch_staged)
                         ? (pwdata[SW-1:0]
                            & {NUM_CH{tet_pkg::CH_WR_MASK}})
                         : ch_staged_ff;

    // writing one requests a commutation; the register itself reads zero
    assign sw_comm = wr_en && hit_comm_req
                  && pwdata[tet_pkg::COMM_REQ_BIT];

    assign stat_word = {28'h000_0000, pol_sig, trig_in_ff,
                        ext_trig_prescaled, flt_bus.dout};

    assign rd_word = hit_ctrl_two   ? ctrl_two_ff :
                     hit_slave_mode ? {16'h0000, slave_mode_ff} :
                     hit_ch_staged  ? 32'(ch_staged_ff) :
                     hit_ch_active  ? 32'(ch_active_word) :
                     hit_trig_stat  ? stat_word :
                     32'h0000_0000;
    assign nxt_prdata = setup_rd ? rd_word : prdata_ff;
    assign prdata     = prdata_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_two_ff   <= tet_pkg::CT_RESET;
            slave_mode_ff <= tet_pkg::SMC_RESET;
            ch_staged_ff  <= '0;
            prdata_ff     <= 32'h0000_0000;
        end else begin
            ctrl_two_ff   <= nxt_ctrl_two;
            slave_mode_ff <= nxt_slave_mode;
            ch_staged_ff  <= nxt_ch_staged;
            prdata_ff     <= nxt_prdata;
        end
    end

    // ---------------- external trigger path ----------------
    // pin is asynchronous: two flops before anything looks at it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
        end else begin
            pin_meta_ff <= ext_trig_pin;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign pol_sig  = pin_sync_ff ^ ext_trig_polarity;
    assign pol_rise = pol_sig && !pol_prev_ff;

    // ripple of rising edges; bit k toggles every 2^k edges
    assign nxt_psc_cnt = pol_rise ? psc_cnt_ff + 3'h1 : psc_cnt_ff;
    assign ext_trig_prescaled = (ext_trig_prescale == 2'h0) ? pol_sig
                              : psc_cnt_ff[ext_trig_prescale - 2'h1];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pol_prev_ff <= 1'b0;
            psc_cnt_ff  <= 3'h0;
        end else begin
            pol_prev_ff <= pol_sig;
            psc_cnt_ff  <= nxt_psc_cnt;
        end
    end

    // filter sits after the prescaler, so it sees the divided rate
    assign flt_bus.code = ext_trig_filter;
    assign flt_bus.din  = ext_trig_prescaled;

    tet_ext_trig_filter #(
        .DTS_DIV (DTS_DIV)
    ) u_filter (
        .ref_clk (ref_clk),
        .reset   (reset),
        .flt     (flt_bus.filt)
    );

    assign ext_trig_filtered = flt_bus.dout;
    assign filt_rise = flt_bus.dout && !filt_prev_ff;

    // ---------------- trigger input selection ----------------
    assign trig_src = {flt_bus.dout, ti2_filtered, ti1_filtered,
                       ti1_edge, int_trig};
    assign trigger_input = trig_in_ff;
    assign trigger_rise  = trig_in_ff && !trig_prev_ff;

    // mode 2 wins over mode 1 when both are on
    assign nxt_clk_tick = ext_clk2_enable ? filt_rise
                        : (slave_mode_cur == tet_pkg::SMO_EXT_CLK1)
                          && trigger_rise;
    assign ext_clk_tick = clk_tick_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            filt_prev_ff <= 1'b0;
            trig_in_ff   <= 1'b0;
            trig_prev_ff <= 1'b0;
            clk_tick_ff  <= 1'b0;
        end else begin
            filt_prev_ff <= flt_bus.dout;
            trig_in_ff   <= trig_src[trigger_select];
            trig_prev_ff <= trig_in_ff;
            clk_tick_ff  <= nxt_clk_tick;
        end
    end

    assign master_slave_sync = slave_mode_ff[tet_pkg::SMC_MSS_BIT];
    assign slave_mode_select = slave_mode_cur;

    // ---------------- commutation and channel preload ----------------
    assign comm_now   = sw_comm || (cc_update_select && trigger_rise);
    assign comm_event = comm_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            comm_ff <= 1'b0;
        end else begin
            comm_ff <= comm_now;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            logic [4:0] stg;
            logic [4:0] act_ff;
            logic [4:0] nxt_act;
            logic       hold;

            assign stg = {
                ch_staged_ff[gi*tet_pkg::CH_STRIDE
                             + tet_pkg::CH_MODE_LSB +: 3],
                ch_staged_ff[gi*tet_pkg::CH_STRIDE + tet_pkg::CH_CE_BIT],
                ch_staged_ff[gi*tet_pkg::CH_STRIDE + tet_pkg::CH_OE_BIT]};

            // plain channels ignore preload entirely
            assign hold    = (gi < NUM_COMP) && cc_preload_ctrl;
            assign nxt_act = (!hold || comm_now) ? stg : act_ff;

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    act_ff <= 5'h00;
                end else begin
                    act_ff <= nxt_act;
                end
            end

            assign channel_out_en[gi]      = act_ff[0];
            assign channel_comp_out_en[gi] = act_ff[1];
            assign channel_out_mode[gi*3 +: 3] = act_ff[4:2];
            assign ch_active_word[gi*tet_pkg::CH_STRIDE +:
                                  tet_pkg::CH_STRIDE] =
                {1'b0, act_ff[4:2], 2'b00, act_ff[1:0]};
        end
    endgenerate

endmodule

// *** dv/tet_trig_properties.sv ***
// concurrent checks on the trigger timer top ports
module tet_trig_properties #(
    parameter int unsigned NUM_CH = 4
) (
    input wire logic              ref_clk,
    input wire logic              reset,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pslverr,
    input wire logic              ext_trig_filtered,
    input wire logic              trigger_input,
    input wire logic              trigger_rise,
    input wire logic              ext_clk_tick,
    input wire logic              comm_event,
    input wire logic [2:0]        slave_mode_select,
    input wire logic [NUM_CH-1:0] channel_out_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic acc_wr   = psel & penable & pwrite;
    wire logic wr_smc   = acc_wr & (paddr == tet_pkg::OFS_SLAVE_MODE);
    wire logic wr_stg   = acc_wr & (paddr == tet_pkg::OFS_CH_STAGED);
    wire logic wr_ctl   = acc_wr & (paddr == tet_pkg::OFS_CTRL_TWO);
    wire logic comm_req = acc_wr & (paddr == tet_pkg::OFS_COMM_REQ)
                          & pwdata[0];
    wire logic mapped   = paddr inside {tet_pkg::OFS_CTRL_TWO,
        tet_pkg::OFS_SLAVE_MODE, tet_pkg::OFS_COMM_REQ,
        tet_pkg::OFS_CH_STAGED, tet_pkg::OFS_CH_ACTIVE,
        tet_pkg::OFS_TRIG_STAT};

    a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_comm_sw: assert property (comm_req |=> comm_event)
        else $error("software commutation gave no event");
    a_comm_cause: assert property (
        comm_event |-> $past(comm_req) || $past(trigger_rise))
        else $error("commutation event without a cause");
    a_rise_edge: assert property (
        trigger_rise |-> trigger_input && !$past(trigger_input))
        else $error("trigger rise without an input edge");
    a_tick_cause: assert property (ext_clk_tick |->
        $past(trigger_rise) ||
        ($past(ext_trig_filtered) && !$past(ext_trig_filtered, 2)))
        else $error("clock tick without a trigger rise");
    a_tick_once: assert property (ext_clk_tick |=> !ext_clk_tick)
        else $error("clock tick longer than one cycle");
    a_mode_echo: assert property (
        wr_smc |=> slave_mode_select == $past(pwdata[2:0]))
        else $error("slave mode field not taken from write");
    a_chan_commit: assert property ($changed(channel_out_en) |->
        comm_event || $past(wr_stg, 2) || $past(wr_ctl, 2))
        else $error("active channel enables changed without cause");
endmodule

bind tet_trig_top tet_trig_properties #(.NUM_CH(NUM_CH))
    i_tet_trig_properties (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .ext_trig_filtered(ext_trig_filtered), .trigger_input(trigger_input),
    .trigger_rise(trigger_rise), .ext_clk_tick(ext_clk_tick),
    .comm_event(comm_event), .slave_mode_select(slave_mode_select),
    .channel_out_en(channel_out_en));

// *** dv/tet_trig_src.sv ***
// external trigger pin source facing the timer block
module tet_trig_src (
    input wire logic ref_clk,
    output logic     ext_trig_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ext_trig_pin = 1'b0;
    // pin idles low, as a pulled-down line would
    task automatic pulse(input int hi, input int lo);
        @(posedge ref_clk);
        ext_trig_pin <= 1'b1;
        repeat (hi) @(posedge ref_clk);
        ext_trig_pin <= 1'b0;
        repeat (lo) @(posedge ref_clk);
    endtask
    // callers keep hi + lo >= 8 so the rate stays legal
    task automatic burst(input int n, input int hi, input int lo);
        repeat (n) pulse(hi, lo);
    endtask
endmodule

// *** dv/tet_trig_top_tb.sv ***
// self-checking bench for the trigger timer top
module tet_trig_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_trig_pin;
    logic        ext_trig_filtered;
    logic        trigger_input;
    logic        trigger_rise;
    logic        ext_clk_tick;
    logic        comm_event;
    logic [2:0]  slave_mode_select;
    logic [3:0]  channel_out_en;
    logic [3:0]  channel_comp_out_en;
    logic        msync;
    logic [11:0] ch_mode;
    logic        ti1_f = 1'b0;
    logic [31:0] rd;
    logic        err;
    logic        filt_q = 1'b0;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          tick_cnt = 0;
    int          rise_cnt = 0;
    int          comm_cnt = 0;
    int          filt_cnt = 0;

    tet_trig_top #(.NUM_CH(4), .NUM_COMP(3), .DTS_DIV(1)) i_tet_trig_top (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_trig_pin(ext_trig_pin),
        .int_trig(4'h0), .ti1_edge(1'b0), .ti1_filtered(ti1_f),
        .ti2_filtered(1'b0), .ext_trig_filtered(ext_trig_filtered),
        .trigger_input(trigger_input), .trigger_rise(trigger_rise),
        .ext_clk_tick(ext_clk_tick), .comm_event(comm_event),
        .master_slave_sync(msync), .slave_mode_select(slave_mode_select),
        .channel_out_en(channel_out_en),
        .channel_comp_out_en(channel_comp_out_en),
        .channel_out_mode(ch_mode));
    tet_trig_src i_tet_trig_src (.ref_clk(ref_clk),
        .ext_trig_pin(ext_trig_pin));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        filt_q <= ext_trig_filtered;
        if (ext_clk_tick === 1'b1) tick_cnt++;
        if (trigger_rise === 1'b1) rise_cnt++;
        if (comm_event === 1'b1) comm_cnt++;
        if (ext_trig_filtered === 1'b1 && filt_q === 1'b0) filt_cnt++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_regs();
        apb(1'b0, tet_pkg::OFS_SLAVE_MODE, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, tet_pkg::OFS_SLAVE_MODE, 32'h0000_ffff);
        apb(1'b0, tet_pkg::OFS_SLAVE_MODE, 32'h0000_0000);
        chk(rd, 32'h0000_fff7);
        chk({29'h0, slave_mode_select}, 32'h0000_0007);
        chk({31'h0, msync}, 32'h0000_0001);
        // selection field is frozen while a slave mode is active
        apb(1'b1, tet_pkg::OFS_SLAVE_MODE, 32'h0000_0000);
        apb(1'b0, tet_pkg::OFS_SLAVE_MODE, 32'h0000_0000);
        chk(rd, 32'h0000_0070);
        apb(1'b1, tet_pkg::OFS_SLAVE_MODE, 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000);
        chk({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, tet_pkg::OFS_CTRL_TWO, 32'hffff_ffff);
        apb(1'b0, tet_pkg::OFS_CTRL_TWO, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        $display("test regs done");
    endtask

    task automatic t_chan();
        int c0;
        apb(1'b1, tet_pkg::OFS_CTRL_TWO, 32'h0000_0001);
        apb(1'b1, tet_pkg::OFS_CH_STAGED, 32'h7373_7373);
        apb(1'b0, tet_pkg::OFS_CH_ACTIVE, 32'h0000_0000);
        chk(rd, 32'h7300_0000);
        c0 = comm_cnt;
        apb(1'b1, tet_pkg::OFS_COMM_REQ, 32'h0000_0001);
        apb(1'b0, tet_pkg::OFS_CH_ACTIVE, 32'h0000_0000);
        chk(rd, 32'h7373_7373);
        chk({channel_comp_out_en, channel_out_en}, 32'h0000_00ff);
        chk({20'h0, ch_mode}, 32'h0000_0fff);
        chk(comm_cnt - c0, 1);
        apb(1'b1, tet_pkg::OFS_CTRL_TWO, 32'h0000_0000);
        apb(1'b1, tet_pkg::OFS_CH_STAGED, 32'h1212_1212);
        apb(1'b0, tet_pkg::OFS_CH_ACTIVE, 32'h0000_0000);
        chk(rd, 32'h1212_1212);
        $display("test chan done");
    endtask

    task automatic t_path();
        int t0;
        int r0;
        int c0;
        apb(1'b1, tet_pkg::OFS_CTRL_TWO, 32'h0000_0005);
        for (int p = 0; p < 4; p++) begin
            // slave mode stays internal, so selection 7 is legal
            apb(1'b1, tet_pkg::OFS_SLAVE_MODE, 32'h0000_4070 | (p << 12));
            // prescaler keeps counting across writes: let the switch settle
            repeat (6) @(posedge ref_clk);
            t0 = tick_cnt;
            r0 = rise_cnt;
            c0 = comm_cnt;
            i_tet_trig_src.burst(16, 4, 4);
            repeat (12) @(posedge ref_clk);
            chk(tick_cnt - t0, 16 >> p);
            chk(rise_cnt - r0, 16 >> p);
            chk(comm_cnt - c0, 16 >> p);
        end
        apb(1'b1, tet_pkg::OFS_SLAVE_MODE, 32'h0000_0050);
        ti1_f <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({31'h0, trigger_input}, 32'h0000_0001);
        apb(1'b1, tet_pkg::OFS_SLAVE_MODE, 32'h0000_8070);
        repeat (10) @(posedge ref_clk);
        chk({31'h0, ext_trig_filtered}, 32'h0000_0001);
        apb(1'b0, tet_pkg::OFS_TRIG_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_000f);
        $display("test path done");
    endtask

    task automatic t_filter();
        int fc[4] = '{1, 3, 6, 15};
        int fn[4] = '{2, 8, 8, 8};
        int fd[4] = '{0, 0, 2, 5};
        int per;
        int need;
        int f0;
        apb(1'b1, tet_pkg::OFS_CTRL_TWO, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            per = 1 << fd[i];
            need = fn[i] * per;
            apb(1'b1, tet_pkg::OFS_SLAVE_MODE, 32'h0000_0070 | (fc[i] << 8));
            repeat (need + 8) @(posedge ref_clk);
            f0 = filt_cnt;
            i_tet_trig_src.pulse(need / 2, need + 2 * per + 8);
            chk(filt_cnt - f0, 0);
            i_tet_trig_src.pulse(need + 2 * per + 8, need + 2 * per + 8);
            chk(filt_cnt - f0, 1);
        end
        $display("test filter done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs();
        t_chan();
        t_path();
        t_filter();
        conclude();
    end
endmodule
